// ==== hdl/sound_monitor_pkg.sv ====
/*
 * sound_monitor_pkg: constants and carrier types for the silence / overload monitor.
 * assumes: 16-bit two's complement audio samples, one qualifying strobe per stereo sample.
 */
package sound_monitor_pkg;
    // sample format
    localparam int SAMPLE_W = 16;
    localparam int MAG_W = 15;
    // silence duration: required samples = (code + 1) * 241 * 256 / 7, rounded up
    localparam int DUR_MUL = 241;
    localparam int DUR_SCALE = 256;
    localparam int DUR_DIV = 7;
    localparam logic [19:0] DUR_STEP = 20'(DUR_MUL * DUR_SCALE);
    localparam logic [19:0] DUR_INC = 20'(DUR_DIV);
    localparam logic [19:0] DUR_CNT_RST = 20'h00000;
    // threshold exponents in quarter-octave units (5*log2 dB = one half of a quarter-octave pair)
    localparam logic [5:0] SIL_Q_OFS = 6'h02;  // silence: q = 2*code - 2
    localparam logic [5:0] OVL_Q_OFS = 6'h1d;  // overload: q = 2*code + 29
    // fractional steps of 2^(k/4), scaled by 128
    localparam logic [7:0] FRAC_Q0 = 8'h80;
    localparam logic [7:0] FRAC_Q1 = 8'h98;
    localparam logic [7:0] FRAC_Q2 = 8'hb5;
    localparam logic [7:0] FRAC_Q3 = 8'hd7;
    // pin routing codes
    localparam logic [1:0] ROUTE_MONO = 2'b00;
    localparam logic [1:0] ROUTE_OVL = 2'b01;
    localparam logic [1:0] ROUTE_SIL = 2'b10;
    localparam logic [1:0] ROUTE_OFF = 2'b11;
    // reset values
    localparam logic [MAG_W-1:0] PEAK_RST = 15'h0000;
    localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 16'h0000;

    typedef struct packed {
        logic [SAMPLE_W-1:0] left;
        logic [SAMPLE_W-1:0] right;
    } stereo_t;

    typedef struct packed {
        logic [3:0] quiet_level_sel;
        logic [3:0] quiet_time_sel;
        logic [3:0] clip_level_sel;
        logic flag_route_hi;
        logic flag_route_lo;
        logic flag_a_invert;
        logic flag_b_invert;
    } monitor_cfg_t;
endpackage

// ==== hdl/sound_monitor.sv ====
/*
 * sound_monitor: per-channel silence and overload detection driving two flag pins,
 * with a running positive peak per channel and an untouched audio pass-through.
 * assumes: settings are static or change between samples; peak_read_done pulses once
 * when the controller has finished a peak readout; all inputs are synchronous to mclk.
 */
module sound_monitor #(
    parameter int SAMPLE_BITS = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // audio in from the processing chain
    input wire sound_monitor_pkg::stereo_t sample_in,
    input wire logic sample_valid,
    // settings
    input wire sound_monitor_pkg::monitor_cfg_t cfg,
    // controller has completed a peak readout
    input wire logic peak_read_done,
    // audio out, unchanged
    output sound_monitor_pkg::stereo_t sample_out,
    output logic sample_out_valid,
    // running positive peaks
    output logic [sound_monitor_pkg::MAG_W-1:0] peak_left,
    output logic [sound_monitor_pkg::MAG_W-1:0] peak_right,
    // flag pins
    output logic flag_out_a,
    output logic flag_out_b
);
    import sound_monitor_pkg::*;

    // refuse other sample widths at elaboration; magnitude and peak paths assume 16 bits
    if (SAMPLE_BITS != SAMPLE_W)
    begin
        $error("sound_monitor: only 16-bit samples are supported");
    end

    // linear threshold 2^(q/4), q in quarter-octave steps; result fits 15 bits for q <= 59
    function automatic logic [MAG_W-1:0] quarter_pow(input logic [5:0] q);
        logic [7:0] frac;
        logic [22:0] wide;
        frac = FRAC_Q0;
        unique case (q[1:0])
            2'b00: frac = FRAC_Q0;
            2'b01: frac = FRAC_Q1;
            2'b10: frac = FRAC_Q2;
            2'b11: frac = FRAC_Q3;
        endcase
        wide = (23'(frac) << q[5:2]) >> 7;
        return wide[MAG_W-1:0];
    endfunction

    // magnitude of a sample, full-scale negative saturates
    function automatic logic [MAG_W-1:0] magnitude(input logic [SAMPLE_W-1:0] s);
        logic [SAMPLE_W-1:0] neg;
        neg = -s;
        if (!s[SAMPLE_W-1])
            return s[MAG_W-1:0];
        else if (neg[SAMPLE_W-1])
            return {MAG_W{1'b1}};
        else
            return neg[MAG_W-1:0];
    endfunction

    // positive part only; negative samples count as zero for peaks
    function automatic logic [MAG_W-1:0] positive(input logic [SAMPLE_W-1:0] s);
        return s[SAMPLE_W-1] ? PEAK_RST : s[MAG_W-1:0];
    endfunction

    // quiet when below the level threshold; code 0 accepts digital zero only
    function automatic logic is_quiet(input logic [SAMPLE_W-1:0] s, input logic [3:0] code);
        logic [5:0] q;
        q = {1'b0, code, 1'b0} - SIL_Q_OFS;
        if (code == 4'h0)
            return (s == SAMPLE_RST);
        else
            return (magnitude(s) < quarter_pow(q));
    endfunction

    logic [5:0] clip_q;
    logic [MAG_W-1:0] clip_thr;
    logic [19:0] dur_target;
    logic [MAG_W-1:0] pos_l;
    logic [MAG_W-1:0] pos_r;
    logic quiet_l;
    logic quiet_r;
    logic [19:0] dur_l_r;
    logic [19:0] dur_r_r;
    logic sil_l_r;
    logic sil_r_r;
    logic ovl_l_r;
    logic ovl_r_r;
    logic [MAG_W-1:0] peak_l_r;
    logic [MAG_W-1:0] peak_r_r;
    logic [1:0] route;
    logic raw_a;
    logic raw_b;

    // thresholds follow the live settings, so a change applies on the next sample
    assign clip_q = {1'b0, cfg.clip_level_sel, 1'b0} + OVL_Q_OFS;
    assign clip_thr = quarter_pow(clip_q);
    // counter advances by 7 per sample, so compare against (T+1)*241*256 exactly
    assign dur_target = 20'(({16'h0000, cfg.quiet_time_sel} + 20'h00001) * DUR_STEP);
    assign pos_l = positive(sample_in.left);
    assign pos_r = positive(sample_in.right);
    assign quiet_l = is_quiet(sample_in.left, cfg.quiet_level_sel);
    assign quiet_r = is_quiet(sample_in.right, cfg.quiet_level_sel);

    // audio pass-through, never altered by any detection result
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sample_out <= '0;
            sample_out_valid <= 1'b0;
        end
        else
        begin
            sample_out <= sample_in;
            sample_out_valid <= sample_valid;
        end
    end

    // quiet-time counters and silence flags, one per channel
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            dur_l_r <= DUR_CNT_RST;
            dur_r_r <= DUR_CNT_RST;
            sil_l_r <= 1'b0;
            sil_r_r <= 1'b0;
        end
        else if (sample_valid)
        begin
            if (!quiet_l)
            begin
                dur_l_r <= DUR_CNT_RST;
                sil_l_r <= 1'b0;
            end
            else
            begin
                // stop counting once at or above the target so the counter cannot wrap
                if (dur_l_r < dur_target)
                    dur_l_r <= dur_l_r + DUR_INC;
                sil_l_r <= (dur_l_r + DUR_INC >= dur_target);
            end
            if (!quiet_r)
            begin
                dur_r_r <= DUR_CNT_RST;
                sil_r_r <= 1'b0;
            end
            else
            begin
                if (dur_r_r < dur_target)
                    dur_r_r <= dur_r_r + DUR_INC;
                sil_r_r <= (dur_r_r + DUR_INC >= dur_target);
            end
        end
    end

    // running peaks; a read restarts collection but the current sample still counts
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            peak_l_r <= PEAK_RST;
            peak_r_r <= PEAK_RST;
        end
        else if (peak_read_done)
        begin
            peak_l_r <= sample_valid ? pos_l : PEAK_RST;
            peak_r_r <= sample_valid ? pos_r : PEAK_RST;
        end
        else if (sample_valid)
        begin
            if (pos_l > peak_l_r)
                peak_l_r <= pos_l;
            if (pos_r > peak_r_r)
                peak_r_r <= pos_r;
        end
    end

    // sticky overload flags; an overload in the read cycle wins over the release
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ovl_l_r <= 1'b0;
            ovl_r_r <= 1'b0;
        end
        else
        begin
            ovl_l_r <= (sample_valid && pos_l > clip_thr) || (ovl_l_r && !peak_read_done);
            ovl_r_r <= (sample_valid && pos_r > clip_thr) || (ovl_r_r && !peak_read_done);
        end
    end

    // pin routing, then per-pin polarity
    assign route = {cfg.flag_route_hi, cfg.flag_route_lo};
    always_comb
    begin
        raw_a = 1'b0;
        raw_b = 1'b0;
        unique case (route)
            ROUTE_MONO:
            begin
                raw_a = ovl_l_r | ovl_r_r;
                raw_b = sil_l_r & sil_r_r;
            end
            ROUTE_OVL:
            begin
                raw_a = ovl_l_r;
                raw_b = ovl_r_r;
            end
            ROUTE_SIL:
            begin
                raw_a = sil_l_r;
                raw_b = sil_r_r;
            end
            ROUTE_OFF:
            begin
                raw_a = 1'b0;
                raw_b = 1'b0;
            end
        endcase
    end

    // registered pins; reset drives them low, then from the first edge they show inactive with the polarity then selected
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            flag_out_a <= 1'b0;
            flag_out_b <= 1'b0;
        end
        else
        begin
            flag_out_a <= raw_a ^ cfg.flag_a_invert;
            flag_out_b <= raw_b ^ cfg.flag_b_invert;
        end
    end

    assign peak_left = peak_l_r;
    assign peak_right = peak_r_r;
endmodule

// ==== bench/sound_monitor_sva.sv ====
/* sound_monitor_sva: port-level assertions for the sound monitor.
   assumes it is bound onto sound_monitor; level checks use codes 15. */
module sound_monitor_sva
    import sound_monitor_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // inputs
    input wire stereo_t sample_in,
    input wire logic sample_valid,
    input wire monitor_cfg_t cfg,
    input wire logic peak_read_done,
    // outputs
    input wire stereo_t sample_out,
    input wire logic sample_out_valid,
    input wire logic [MAG_W-1:0] peak_left,
    input wire logic [MAG_W-1:0] peak_right,
    input wire logic flag_out_a,
    input wire logic flag_out_b
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // pin a routed to left overload, or to left silence, both active high
    sequence s_loud_left;
        sample_valid && cfg.clip_level_sel == 4'hf && $signed(sample_in.left) > 16'sh6b80
            && cfg.flag_route_lo && !cfg.flag_route_hi && !cfg.flag_a_invert;
    endsequence
    sequence s_noisy_left;
        sample_valid && cfg.quiet_level_sel == 4'hf && $signed(sample_in.left) >= 16'sh0080
            && cfg.flag_route_hi && !cfg.flag_route_lo && !cfg.flag_a_invert;
    endsequence

    property p_pass_through;
        sample_valid |=> sample_out_valid && sample_out == $past(sample_in);
    endproperty
    a_pass_through: assert property (p_pass_through) else $error("audio altered");
    property p_idle_quiet;
        !sample_valid |=> !sample_out_valid;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("stray valid");
    // the flag pin trails the sample by two edges, so settings must hold meanwhile
    property p_overload_rise;
        s_loud_left ##1 $stable(cfg) |=> flag_out_a;
    endproperty
    a_overload_rise: assert property (p_overload_rise) else $error("overload missed");
    property p_loud_drops_quiet;
        s_noisy_left ##1 $stable(cfg) |=> !flag_out_a;
    endproperty
    a_loud_drops_quiet: assert property (p_loud_drops_quiet) else $error("silence kept");
    property p_overload_held;
        cfg.flag_route_lo && !cfg.flag_route_hi && !cfg.flag_a_invert && $stable(cfg) && flag_out_a
            && !$past(peak_read_done) |=> flag_out_a;
    endproperty
    a_overload_held: assert property (p_overload_held) else $error("overload dropped");
    property p_read_clears;
        peak_read_done && !sample_valid |=> peak_left == PEAK_RST && peak_right == PEAK_RST;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("peak not cleared");
    property p_peak_grows;
        !peak_read_done |=> peak_left >= $past(peak_left) && peak_right >= $past(peak_right);
    endproperty
    a_peak_grows: assert property (p_peak_grows) else $error("peak fell");
    property p_route_off;
        (cfg.flag_route_hi && cfg.flag_route_lo && $stable(cfg)) [*2] |->
            flag_out_a == cfg.flag_a_invert && flag_out_b == cfg.flag_b_invert;
    endproperty
    a_route_off: assert property (p_route_off) else $error("pin not idle");
endmodule

bind sound_monitor sound_monitor_sva chk (
    .mclk(mclk),
    .rst(rst),
    .sample_in(sample_in),
    .sample_valid(sample_valid),
    .cfg(cfg),
    .peak_read_done(peak_read_done),
    .sample_out(sample_out),
    .sample_out_valid(sample_out_valid),
    .peak_left(peak_left),
    .peak_right(peak_right),
    .flag_out_a(flag_out_a),
    .flag_out_b(flag_out_b)
);

// ==== bench/sound_monitor_tb.sv ====
/* sound_monitor_tb: directed bench for the sound monitor.
   assumes a 50 MHz clock; inputs move on falling edges, flags lag samples by two edges. */
module sound_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sound_monitor_pkg::*;
    logic mclk = 0;
    logic rst = 1;
    stereo_t sample_in = '0;
    logic sample_valid = 0;
    monitor_cfg_t cfg = '0;
    logic peak_read_done = 0;
    stereo_t sample_out;
    logic sample_out_valid;
    logic [MAG_W-1:0] peak_left;
    logic [MAG_W-1:0] peak_right;
    logic flag_out_a;
    logic flag_out_b;
    int failures = 0;
    int checked = 0;

    sound_monitor dut (
        .mclk(mclk),
        .rst(rst),
        .sample_in(sample_in),
        .sample_valid(sample_valid),
        .cfg(cfg),
        .peak_read_done(peak_read_done),
        .sample_out(sample_out),
        .sample_out_valid(sample_out_valid),
        .peak_left(peak_left),
        .peak_right(peak_right),
        .flag_out_a(flag_out_a),
        .flag_out_b(flag_out_b)
    );

    // free-running clock
    initial
    begin
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic pins(input logic a, input logic b);
        chk(flag_out_a, a);
        chk(flag_out_b, b);
    endtask

    // hold one stereo value for n back-to-back samples, then let the flags settle
    task automatic run(input int n, input logic [15:0] l, input logic [15:0] r);
        sample_in = {l, r};
        sample_valid = 1;
        repeat (n) @(negedge mclk);
        chk(sample_out, {l, r});
        chk(sample_out_valid, 1);
        sample_valid = 0;
        repeat (2) @(negedge mclk);
    endtask

    task automatic results;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog: tests need about 18k cycles, so 50k means a hang
    initial
    begin
        #1ms;
        failures++;
        results;
    end

    // directed sequence
    initial
    begin
        repeat (3) @(negedge mclk);
        rst = 0;
        @(negedge mclk);
        pins(0, 0);
        cfg.clip_level_sel = 4'hf;
        cfg.flag_route_lo = 1;
        run(1, 16'h0000, 16'h6b80);
        pins(0, 0);
        run(1, 16'h6b81, 16'h0000);
        pins(1, 0);
        chk(peak_left, 15'h6b81);
        run(4, 16'h0000, 16'h8000);
        pins(1, 0);
        // lowest overload code: 152 is on the level, 153 is above it
        cfg.clip_level_sel = 4'h0;
        run(1, 16'h0000, 16'h0098);
        pins(1, 0);
        run(1, 16'h0000, 16'h0099);
        pins(1, 1);
        cfg.flag_route_lo = 0;
        repeat (2) @(negedge mclk);
        pins(1, 0);
        cfg.flag_a_invert = 1;
        cfg.flag_b_invert = 1;
        repeat (2) @(negedge mclk);
        pins(0, 1);
        cfg.flag_route_hi = 1;
        cfg.flag_route_lo = 1;
        repeat (2) @(negedge mclk);
        pins(1, 1);
        cfg.flag_a_invert = 0;
        cfg.flag_b_invert = 0;
        cfg.flag_route_hi = 0;
        peak_read_done = 1;
        @(negedge mclk);
        peak_read_done = 0;
        chk(peak_right, 15'h0000);
        repeat (2) @(negedge mclk);
        pins(0, 0);
        // shortest quiet time needs 8814 quiet samples; +127 and -127 sit below code 15
        cfg.flag_route_hi = 1;
        cfg.flag_route_lo = 0;
        cfg.quiet_level_sel = 4'hf;
        // earlier zero samples already ran the quiet counters; a loud pair restarts both
        run(1, 16'h0080, 16'hff80);
        pins(0, 0);
        run(8813, 16'h007f, 16'hff81);
        pins(0, 0);
        run(1, 16'h007f, 16'hff81);
        pins(1, 1);
        // a longer quiet time applies on the next sample, the shorter one again after it
        cfg.quiet_time_sel = 4'h1;
        run(1, 16'h007f, 16'hff81);
        pins(0, 0);
        cfg.quiet_time_sel = 4'h0;
        run(1, 16'h007f, 16'hff81);
        pins(1, 1);
        cfg.flag_route_hi = 0;
        repeat (2) @(negedge mclk);
        pins(0, 1);
        cfg.flag_route_hi = 1;
        run(1, 16'h0080, 16'h0000);
        pins(0, 1);
        // code zero: only digital zero counts as quiet
        cfg.quiet_level_sel = 4'h0;
        run(8814, 16'h0001, 16'h0000);
        pins(0, 1);
        results;
    end
endmodule
